// file: rtl/tppl_pkg.sv
package tppl_pkg;

  // Object indices as seen by the fieldbus object dictionary.
  localparam logic [15:0] IDX_FUNC = 16'h60b8;
  localparam logic [15:0] IDX_STAT = 16'h60b9;
  localparam logic [15:0] IDX_POS1R = 16'h60ba;
  localparam logic [15:0] IDX_POS1F = 16'h60bb;
  localparam logic [15:0] IDX_POS2R = 16'h60bc;
  localparam logic [15:0] IDX_POS2F = 16'h60bd;

  // Widths.
  localparam int WORD_W = 16;
  localparam int POS_W = 32;
  localparam int CH_N = 2;
  localparam int CH_BITS = 8;

  // Function byte field positions, the same in both channel bytes.
  localparam int FB_EN = 0;
  localparam int FB_CONT = 1;
  localparam int FB_SRC = 2;
  localparam int FB_RISE = 4;
  localparam int FB_FALL = 5;

  // Status byte field positions.
  localparam int SB_EN = 0;
  localparam int SB_RISE = 1;
  localparam int SB_FALL = 2;
  localparam int SB_CNT = 6;

  // Reset values and the mask of function bits that have an effect.
  localparam logic [15:0] FUNC_RST = 16'h0000;
  localparam logic [15:0] FUNC_MASK = 16'h3737;
  localparam logic [31:0] POS_RST = 32'h0000_0000;
  localparam logic [1:0] CNT_RST = 2'h0;

endpackage

// file: rtl/tppl_top.sv
// Function
// R1: Capture feedback position when a selected probe edge or zero pulse occurs.
// R2: Two independent channels run concurrently without interfering.
// R3: Channel one uses function low byte and status low byte.
// R4: Channel two uses function high byte, same layout, status high byte.
// R5: Channel one rising and falling captures go to its own two holders.
// R6: Channel two rising and falling captures go to its own two holders.
// R7: Enable bit enables the channel; no capture while disabled.
// R8: Mode bit clear gives single-shot: only the first qualifying event; the code takes the first rising and the first falling capture.
// R9: Mode bit set gives continuous capture on every qualifying event.
// R10: Channel one source bit picks probe input one or the zero pulse.
// R11: Channel two source bit picks probe input two or the zero pulse.
// R12: Rising-edge sampling only when bits 4 and 12 are set.
// R13: Falling-edge sampling only when bits 5 and 13 are set.
// R14: Status bits 0 and 8 mirror the channel enables.
// R15: Status bits 1 and 9 flag a stored rising capture.
// R16: Status bits 2 and 10 flag a stored falling capture.
// R17: In continuous mode a 2-bit counter per channel wraps on each capture.
// R18: Enabling a channel clears its flags and counter and re-arms it.
// R19: Controller writes zero to reserved function bits; they have no effect.
module tppl_top (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Object access from the fieldbus side.
  input wire logic obj_wr_i,
  input wire logic obj_rd_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [31:0] obj_wdata_i,
  output logic [31:0] obj_rdata_o,
  output logic obj_rvalid_o,
  output logic obj_err_o,
  // Position feedback, same clock.
  input wire logic [31:0] fb_position_i,
  // Asynchronous trigger sources.
  input wire logic probe_input_one_i,
  input wire logic probe_input_two_i,
  input wire logic enc_zero_i,
  // Live status for local use.
  output logic [15:0] probe_status_o
);

  ////////////////////////////////////////////////////////////////////////////

  // Source index of the shared encoder zero pulse.
  localparam int ZERO_IDX = 2;
  localparam int SRC_N = 3;

  logic [SRC_N-1:0] pins;
  logic [SRC_N-1:0] sync1_reg;
  logic [SRC_N-1:0] sync2_reg;
  logic [SRC_N-1:0] prev_reg;
  logic [SRC_N-1:0] rise_evt;
  logic [SRC_N-1:0] fall_evt;

  logic func_hit;
  logic [15:0] func_reg;
  logic [15:0] func_next;

  wire logic [7:0] ch_stat [0:1];
  wire logic [31:0] ch_rise_pos [0:1];
  wire logic [31:0] ch_fall_pos [0:1];
  logic [15:0] status;

  logic idx_known;
  logic wr_bad;
  logic rd_bad;
  logic [31:0] rdata_next;
  logic rvalid_next;
  logic err_next;
  logic [31:0] obj_rdata_reg;
  logic obj_rvalid_reg;
  logic obj_err_reg;

  ////////////////////////////////////////////////////////////////////////////

  assign pins = {enc_zero_i, probe_input_two_i, probe_input_one_i};

  // Only the second stage is read by logic, so a metastable first stage
  // never reaches the edge detector.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= '0;
    end else begin
      sync1_reg <= pins;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync2_reg <= '0;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= sync2_reg;
    end
  end

  // Idle pins are low and the detector resets low, so no false edge.
  assign rise_evt = sync2_reg & ~prev_reg; // [R1]
  assign fall_evt = ~sync2_reg & prev_reg; // [R1]

  ////////////////////////////////////////////////////////////////////////////

  assign func_hit = obj_wr_i && (obj_index_i == tppl_pkg::IDX_FUNC);

  // Reserved bits are dropped on write, so they read back as zero.
  always_comb begin
    func_next = func_reg;
    if (func_hit) begin
      func_next = obj_wdata_i[15:0] & tppl_pkg::FUNC_MASK; // [R19]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      func_reg <= tppl_pkg::FUNC_RST;
    end else begin
      func_reg <= func_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  for (genvar c = 0; c < tppl_pkg::CH_N; c++) begin : g_ch // [R2]
    localparam int LSB = c * tppl_pkg::CH_BITS;
    logic [7:0] cfg;
    logic en;
    logic cont;
    logic use_zero;
    logic rise_on;
    logic fall_on;
    logic en_d_reg;
    logic rearm;
    logic src_rise;
    logic src_fall;
    logic cap_rise;
    logic cap_fall;
    logic rise_arm_reg;
    logic fall_arm_reg;
    logic rise_st_reg;
    logic fall_st_reg;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic [31:0] rise_pos_reg;
    logic [31:0] fall_pos_reg;
    logic [7:0] stat;

    assign cfg = func_reg[LSB +: tppl_pkg::CH_BITS]; // [R3] [R4]
    assign en = cfg[tppl_pkg::FB_EN]; // [R7]
    assign cont = cfg[tppl_pkg::FB_CONT]; // [R8] [R9]
    assign use_zero = cfg[tppl_pkg::FB_SRC]; // [R10] [R11]
    assign rise_on = cfg[tppl_pkg::FB_RISE]; // [R12]
    assign fall_on = cfg[tppl_pkg::FB_FALL]; // [R13]

    // An event in the cycle that enables the channel is dropped, so the
    // holders never disagree with the freshly cleared flags.
    assign rearm = en && !en_d_reg; // [R18]

    // The zero pulse is shared: both channels may capture the same edge.
    always_comb begin
      src_rise = rise_evt[c];
      src_fall = fall_evt[c];
      if (use_zero) begin
        src_rise = rise_evt[ZERO_IDX]; // [R10] [R11]
        src_fall = fall_evt[ZERO_IDX]; // [R10] [R11]
      end
    end

    // Single-shot is held per edge: one rising and one falling capture
    // are possible after each enable.
    assign cap_rise = en && rise_on && src_rise && !rearm &&
      (cont || rise_arm_reg); // [R1] [R7] [R8] [R9] [R12]
    assign cap_fall = en && fall_on && src_fall && !rearm &&
      (cont || fall_arm_reg); // [R1] [R7] [R8] [R9] [R13]

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        en_d_reg <= 1'b0;
      end else begin
        en_d_reg <= en;
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rise_arm_reg <= 1'b0;
      end else if (rearm) begin
        rise_arm_reg <= 1'b1; // [R18]
      end else if (cap_rise) begin
        rise_arm_reg <= 1'b0; // [R8]
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        fall_arm_reg <= 1'b0;
      end else if (rearm) begin
        fall_arm_reg <= 1'b1; // [R18]
      end else if (cap_fall) begin
        fall_arm_reg <= 1'b0; // [R8]
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rise_st_reg <= 1'b0;
      end else if (rearm) begin
        rise_st_reg <= 1'b0; // [R18]
      end else if (cap_rise) begin
        rise_st_reg <= 1'b1; // [R15]
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        fall_st_reg <= 1'b0;
      end else if (rearm) begin
        fall_st_reg <= 1'b0; // [R18]
      end else if (cap_fall) begin
        fall_st_reg <= 1'b1; // [R16]
      end
    end

    // Both edges in one cycle are impossible on one source, so one step.
    always_comb begin
      cnt_next = cnt_reg;
      if (cont && (cap_rise || cap_fall)) begin
        cnt_next = cnt_reg + 2'h1; // [R17]
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_reg <= tppl_pkg::CNT_RST;
      end else if (rearm) begin
        cnt_reg <= tppl_pkg::CNT_RST; // [R18]
      end else begin
        cnt_reg <= cnt_next; // [R17]
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        rise_pos_reg <= tppl_pkg::POS_RST;
      end else if (cap_rise) begin
        rise_pos_reg <= fb_position_i; // [R1] [R5] [R6]
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        fall_pos_reg <= tppl_pkg::POS_RST;
      end else if (cap_fall) begin
        fall_pos_reg <= fb_position_i; // [R1] [R5] [R6]
      end
    end

    // Reserved status bits stay zero.
    always_comb begin
      stat = 8'h00;
      stat[tppl_pkg::SB_EN] = en; // [R14]
      stat[tppl_pkg::SB_RISE] = rise_st_reg; // [R15]
      stat[tppl_pkg::SB_FALL] = fall_st_reg; // [R16]
      stat[tppl_pkg::SB_CNT +: 2] = cnt_reg; // [R17]
    end

    assign ch_stat[c] = stat; // [R3] [R4]
    assign ch_rise_pos[c] = rise_pos_reg; // [R5] [R6]
    assign ch_fall_pos[c] = fall_pos_reg; // [R5] [R6]
  end

  ////////////////////////////////////////////////////////////////////////////

  assign status = {ch_stat[1], ch_stat[0]}; // [R3] [R4]
  assign probe_status_o = status; // [R14]

  ////////////////////////////////////////////////////////////////////////////

  // Read data holds until the next read of any index; an unknown index reads as
  // zero and gives no valid pulse.
  always_comb begin
    idx_known = 1'b1;
    rdata_next = obj_rdata_reg;
    unique case (obj_index_i)
      tppl_pkg::IDX_FUNC: rdata_next = {16'h0000, func_reg};
      tppl_pkg::IDX_STAT: rdata_next = {16'h0000, status};
      tppl_pkg::IDX_POS1R: rdata_next = ch_rise_pos[0];
      tppl_pkg::IDX_POS1F: rdata_next = ch_fall_pos[0];
      tppl_pkg::IDX_POS2R: rdata_next = ch_rise_pos[1];
      tppl_pkg::IDX_POS2F: rdata_next = ch_fall_pos[1];
      default: begin
        idx_known = 1'b0;
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Only the function word takes writes; anything else is refused with an
  // error pulse and has no effect.
  assign wr_bad = obj_wr_i && (obj_index_i != tppl_pkg::IDX_FUNC);
  assign rd_bad = obj_rd_i && !idx_known;

  always_comb begin
    rvalid_next = 1'b0;
    err_next = wr_bad || rd_bad;
    if (obj_rd_i && idx_known) begin
      rvalid_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      obj_rdata_reg <= 32'h0000_0000;
    end else if (obj_rd_i) begin
      obj_rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      obj_rvalid_reg <= 1'b0;
    end else begin
      obj_rvalid_reg <= rvalid_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      obj_err_reg <= 1'b0;
    end else begin
      obj_err_reg <= err_next;
    end
  end

  assign obj_rdata_o = obj_rdata_reg;
  assign obj_rvalid_o = obj_rvalid_reg;
  assign obj_err_o = obj_err_reg;

endmodule

// file: tb/tppl_top_properties.sv
module tppl_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic obj_wr_i,
  input wire logic obj_rd_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [31:0] obj_wdata_i,
  input wire logic [31:0] obj_rdata_o,
  input wire logic obj_rvalid_o,
  input wire logic obj_err_o,
  input wire logic [15:0] probe_status_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Shadow of the function word, so causes can be checked at the ports.
  logic [15:0] fq;
  logic ok;
  logic [15:0] s;
  assign s = probe_status_o;
  assign ok = obj_index_i >= tppl_pkg::IDX_FUNC &&
    obj_index_i <= tppl_pkg::IDX_POS2F;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fq <= 16'h0000;
    end else if (obj_wr_i && obj_index_i == tppl_pkg::IDX_FUNC) begin
      fq <= obj_wdata_i[15:0] & tppl_pkg::FUNC_MASK;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_ok;
    obj_rd_i && ok;
  endsequence
  chk_read_answer: assert property (rd_ok |=> obj_rvalid_o)
    else $error("read not answered");
  chk_bad_read: assert property (obj_rd_i && !ok |=> obj_err_o)
    else $error("bad read not refused");
  chk_func_back: assert property (rd_ok ##0 obj_index_i == 16'h60b8
    |=> obj_rdata_o[15:0] == $past(fq)) else $error("function readback");
  chk_en_mirror: assert property (s[0] == fq[0] && s[8] == fq[8])
    else $error("enable mirror");
  chk_rise_cause: assert property ($rose(s[1]) |-> $past(fq[4] && fq[0]))
    else $error("rising capture without cause");
  chk_fall_cause: assert property ($rose(s[10]) |-> $past(fq[13] && fq[8]))
    else $error("falling capture without cause");
  chk_cnt_step: assert property ($changed(s[15:14]) |-> s[15:14] == 2'h0
    || s[15:14] == $past(s[15:14]) + 2'h1) else $error("counter step");
  chk_idle_hold: assert property (!$past(fq[0]) && !fq[0] |-> $stable(s[7:0]))
    else $error("disabled channel changed");
endmodule
bind tppl_top tppl_chk chk_u (.clk_i, .rst_n_i, .obj_wr_i, .obj_rd_i,
  .obj_index_i, .obj_wdata_i, .obj_rdata_o, .obj_rvalid_o, .obj_err_o,
  .probe_status_o);

// file: tb/tppl_host.sv
module tppl_host (
  input wire logic clk_i,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [15:0] idx_o = 16'h0000,
  output logic [31:0] wd_o = 32'h0000_0000,
  input wire logic [31:0] rdata_i,
  input wire logic err_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle index and write data are inverted and both strobes are low, so a stale index is never taken as live.
  task automatic access(input logic w, input logic [15:0] i,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_i);
    #1;
    wr_o = w;
    rd_o = !w;
    idx_o = i;
    wd_o = d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    idx_o = ~i;
    wd_o = ~d;
    r = rdata_i;
    e = err_i;
  endtask
endmodule

// file: tb/touch_probe_position_latch_tb.sv
module touch_probe_position_latch_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr, rd, rv, er, e;
  logic [2:0] trig = 3'h0;
  logic [15:0] idx, st;
  logic [31:0] wd, rdat, pos = 32'h0000_0000, r;
  int checked = 0;
  int bad_count = 0;
  always #50 clk_i = ~clk_i;
  tppl_host host_u (.clk_i, .wr_o(wr), .rd_o(rd), .idx_o(idx), .wd_o(wd),
    .rdata_i(rdat), .err_i(er));
  tppl_top dut_u (.clk_i, .rst_n_i, .obj_wr_i(wr), .obj_rd_i(rd),
    .obj_index_i(idx), .obj_wdata_i(wd), .obj_rdata_o(rdat),
    .obj_rvalid_o(rv), .obj_err_o(er), .fb_position_i(pos),
    .probe_input_one_i(trig[0]), .probe_input_two_i(trig[1]),
    .enc_zero_i(trig[2]), .probe_status_o(st));
  task automatic print_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrf(input logic [15:0] i, input logic [31:0] d);
    host_u.access(1'b1, i, d, r, e);
  endtask
  task automatic rdc(input logic [15:0] i, input logic [31:0] x);
    host_u.access(1'b0, i, 32'h0000_0000, r, e);
    check(r, x);
    check({31'h0, rv}, 32'h0000_0001);
  endtask
  // Sets a pin with a fresh position; the wait after it is bounded.
  task automatic pin(input int p, input logic v, input logic [31:0] q, int b);
    int n;
    @(posedge clk_i);
    #1;
    pos = q;
    trig[p] = v;
    for (n = 0; n < 20 && (b < 0 || st[b] !== 1'b1); n++) @(posedge clk_i);
    if (b >= 0 && n == 20) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic t_single;
    wrf(16'h60b8, 32'h0000_0031);
    pin(0, 1'b1, 32'h1111_0001, 1);
    rdc(16'h60ba, 32'h1111_0001);
    pin(0, 1'b0, 32'hfeed_0002, 2);
    rdc(16'h60bb, 32'hfeed_0002);
    pin(0, 1'b1, 32'h2222_0003, -1);
    rdc(16'h60ba, 32'h1111_0001);
    rdc(16'h60b9, 32'h0000_0007);
    rdc(16'h60bc, 32'h0000_0000);
    $display("single-shot test done");
  endtask
  task automatic t_cont;
    wrf(16'h60b8, 32'h0000_3700);
    pin(0, 1'b0, 32'h3333_0004, -1);
    pin(1, 1'b1, 32'h4444_0005, -1);
    rdc(16'h60bb, 32'hfeed_0002);
    pin(2, 1'b1, 32'h5555_0006, 9);
    rdc(16'h60bc, 32'h5555_0006);
    pin(2, 1'b0, 32'h6666_0007, 10);
    rdc(16'h60bd, 32'h6666_0007);
    pin(2, 1'b1, 32'h7777_0008, -1);
    rdc(16'h60bc, 32'h7777_0008);
    rdc(16'h60b9, 32'h0000_c706);
    pin(2, 1'b0, 32'h8888_0009, -1);
    rdc(16'h60b9, 32'h0000_0706);
    $display("continuous test done");
  endtask
  task automatic t_refuse;
    wrf(16'h60b8, 32'h0000_ffff);
    rdc(16'h60b8, 32'h0000_3737);
    rdc(16'h60b9, 32'h0000_0701);
    wrf(16'h60b9, 32'h0000_0000);
    check({31'h0, e}, 32'h0000_0001);
    host_u.access(1'b0, 16'h1234, 32'h0000_0000, r, e);
    check({31'h0, e}, 32'h0000_0001);
    $display("refusal test done");
  endtask
  // Both channels on the shared zero pulse, then one edge enable at a time.
  task automatic t_both;
    pin(2, 1'b1, 32'h9999_000a, 1);
    rdc(16'h60ba, 32'h9999_000a);
    rdc(16'h60bc, 32'h9999_000a);
    check({16'h0000, st}, 32'h0000_4743);
    wrf(16'h60b8, 32'h0000_3727);
    pin(2, 1'b0, 32'haaaa_000b, -1);
    pin(2, 1'b1, 32'hbbbb_000c, -1);
    rdc(16'h60ba, 32'h9999_000a);
    rdc(16'h60bb, 32'haaaa_000b);
    rdc(16'h60bc, 32'hbbbb_000c);
    wrf(16'h60b8, 32'h0000_1727);
    pin(2, 1'b0, 32'hcccc_000d, -1);
    rdc(16'h60bd, 32'haaaa_000b);
    rdc(16'h60bb, 32'hcccc_000d);
    rdc(16'h60b9, 32'h0000_c7c7);
    $display("shared zero pulse test done");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    rdc(16'h60b8, 32'h0000_0000);
    t_single();
    t_cont();
    t_refuse();
    t_both();
    print_verdict();
  end
endmodule
